// ### psm_chk.sv
// checker of the pulse spacing meter ports
`timescale 1ns/10ps
module psm_chk
   import psm_pkg::*;
(
   // clock and reset
   input  wire logic                    i_clk,
   input  wire logic                    i_reset,
   // watched inputs
   input  wire logic                    i_mark,
   input  wire logic                    i_cycle_tick,
   input  wire logic                    i_cmd_valid,
   input  wire psm_cmd_s                i_cmd,
   // watched outputs
   input  wire logic signed [VAL_W-1:0] o_value,
   input  wire logic                    o_new_value_strobe,
   input  wire logic                    o_pulse_valid_flag,
   input  wire logic                    o_running
);
   logic       mark_q_reg;
   logic [5:0] since_reg;
   logic       rst_cmd;
   assign rst_cmd = i_cmd_valid && (i_cmd.code == CMD_RESET);
   // cycles since the last mark edge; saturates so long gaps never wrap
   always_ff @(posedge i_clk) begin
      mark_q_reg <= i_mark;
      if (i_reset) since_reg <= 6'h3F;
      else if (i_mark && !mark_q_reg) since_reg <= 6'h00;
      else if (since_reg != 6'h3F) since_reg <= since_reg + 6'h01;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   property p_strobe_tick; $rose(o_new_value_strobe) |-> $past(i_cycle_tick); endproperty
   a_strobe_tick: assert property (p_strobe_tick) else $error("strobe rose off tick");
   property p_strobe_hold; o_new_value_strobe && !i_cycle_tick && !i_cmd_valid
      |=> o_new_value_strobe; endproperty
   a_strobe_hold: assert property (p_strobe_hold) else $error("strobe cut short");
   property p_value_tick; $changed(o_value)
      |-> ($past(i_cycle_tick) && o_new_value_strobe) || $past(rst_cmd); endproperty
   a_value_tick: assert property (p_value_tick) else $error("value moved alone");
   property p_strobe_valid; $rose(o_new_value_strobe) |-> o_pulse_valid_flag; endproperty
   a_strobe_valid: assert property (p_strobe_valid) else $error("strobe not valid");
   property p_run_start; i_cmd_valid && i_cmd.code == CMD_START |=> o_running; endproperty
   a_run_start: assert property (p_run_start) else $error("start not taken");
   property p_run_hold; o_running && !rst_cmd |=> o_running; endproperty
   a_run_hold: assert property (p_run_hold) else $error("running dropped");
   property p_reset_cmd; rst_cmd
      |=> !o_running && !o_pulse_valid_flag && !o_new_value_strobe; endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("reset left state");
   property p_idle; !o_running |-> !o_new_value_strobe && !o_pulse_valid_flag; endproperty
   a_idle: assert property (p_idle) else $error("idle output active");
   property p_flag_mark; $rose(o_pulse_valid_flag) |-> since_reg <= 6'h28; endproperty
   a_flag_mark: assert property (p_flag_mark) else $error("flag without mark");
endmodule

bind psm_pulse_spacing_meter psm_chk u_chk (.i_clk, .i_reset, .i_mark, .i_cycle_tick,
   .i_cmd_valid, .i_cmd, .o_value, .o_new_value_strobe, .o_pulse_valid_flag, .o_running);

// ### psm_enc_model.sv
// encoder and mark sensor model driving the pulse generator input
`timescale 1ns/10ps
module psm_enc_model (
   // clock
   input  wire logic i_clk,
   // pulse generator lines
   output logic      o_inc_a,
   output logic      o_inc_b,
   output logic      o_mark
);
   logic ph = 1'b0;
   initial begin
      o_inc_a = 1'b0;
      o_inc_b = 1'b0;
      o_mark = 1'b0;
   end
   // quadrature: lines toggle in turn, one increment edge per clock
   task automatic move(input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge i_clk);
         #1;
         if (ph) o_inc_b = ~o_inc_b;
         else o_inc_a = ~o_inc_a;
         ph = ~ph;
      end
   endtask
   // mark pulse, then a quiet gap longer than one evaluation run
   task automatic mark();
      repeat (4) @(posedge i_clk);
      #1;
      o_mark = 1'b1;
      repeat (3) @(posedge i_clk);
      #1;
      o_mark = 1'b0;
      repeat (40) @(posedge i_clk);
   endtask
endmodule

// ### psm_modulo.sv
// iterative remainder unit: dividend modulo divisor, one bit per cycle
`timescale 1ns/10ps
module psm_modulo
   import psm_pkg::*;
(
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_reset,
   // request
   input  wire logic             i_start,
   input  wire logic [CNT_W-1:0] i_dividend,
   input  wire logic [PAR_W-1:0] i_divisor,
   // answer
   output logic                  o_done,
   output logic [CNT_W-1:0]      o_rem
);

   logic [CNT_W:0]   rem_reg;
   logic [CNT_W-1:0] dq_reg;
   logic [CNT_W-1:0] div_reg;
   logic [5:0]       step_reg;
   logic             busy_reg;
   logic [CNT_W:0]   shifted;

   assign shifted = {rem_reg[CNT_W-1:0], dq_reg[CNT_W-1]};
   assign o_rem   = rem_reg[CNT_W-1:0];

   // restoring division; a zero divisor returns the dividend unchanged
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         rem_reg  <= '0;
         dq_reg   <= '0;
         div_reg  <= '0;
         step_reg <= '0;
         busy_reg <= 1'b0;
         o_done   <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start) begin
            div_reg  <= {2'b00, i_divisor};
            step_reg <= 6'(DIV_STEPS);
            if (i_divisor == PAR_RST) begin
               rem_reg  <= {1'b0, i_dividend};
               busy_reg <= 1'b0;
               o_done   <= 1'b1;
            end else begin
               rem_reg  <= '0;
               dq_reg   <= i_dividend;
               busy_reg <= 1'b1;
            end
         end else if (busy_reg) begin
            dq_reg   <= {dq_reg[CNT_W-2:0], 1'b0};
            step_reg <= step_reg - 6'd1;
            if (shifted >= {1'b0, div_reg}) begin
               rem_reg <= shifted - {1'b0, div_reg};
            end else begin
               rem_reg <= shifted;
            end
            if (step_reg == 6'd1) begin
               busy_reg <= 1'b0;
               o_done   <= 1'b1;
            end
         end
      end
   end

endmodule

// ### psm_pkg.sv
// package: constants and carrier types of the pulse spacing meter
package psm_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int CNT_W = 32;   // increment counter width
   localparam int PAR_W = 30;   // spacing, window and blocked width
   localparam int VAL_W = 32;   // output value width
   localparam int DIV_STEPS = 32;  // cycles of one remainder run

   // ------------------------------------------------------------
   // command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_RESET     = 8'h00;
   localparam logic [7:0] CMD_START     = 8'h01;
   localparam logic [7:0] CMD_VALUE_NEW = 8'h05;

   // ------------------------------------------------------------
   // mode bit positions and limitation codes
   // ------------------------------------------------------------
   localparam int MODE_ABS_BIT    = 0;
   localparam int MODE_RESEED_BIT = 1;
   localparam int MODE_LIM_LSB    = 2;
   localparam logic [1:0] LIM_NONE = 2'h0;
   localparam logic [1:0] LIM_POS  = 2'h1;
   localparam logic [1:0] LIM_NEG  = 2'h2;

   // ------------------------------------------------------------
   // reset values and counter maximum
   // ------------------------------------------------------------
   localparam logic [CNT_W-1:0] CNT_RST  = 32'h0000_0000;
   localparam logic [PAR_W-1:0] PAR_RST  = 30'h0000_0000;
   localparam logic [VAL_W-1:0] VAL_RST  = 32'h0000_0000;
   localparam logic [3:0]       MODE_RST = 4'h0;
   localparam logic [CNT_W-1:0] CNT_MAX  = 32'hFFFF_FFFF;

   // ------------------------------------------------------------
   // command carrier
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]       code;      // command_code
      logic [3:0]       mode;      // mode_bits
      logic [PAR_W-1:0] spacing;   // command spacing
      logic [PAR_W-1:0] window;    // tolerance window, 0 = no window check
      logic [PAR_W-1:0] blocked;   // blocked distance, 0 = none
   } psm_cmd_s;

endpackage

// ### psm_pulse_spacing_meter.sv
// pulse spacing meter: mark-to-mark distance in encoder increments
`timescale 1ns/10ps

// Function
// RQ1: count increment edges between successive mark pulses
// RQ2: mark valid only inside tolerance window
// RQ3: reject marks within blocked distance after valid
// RQ4: new value strobe high one function cycle
// RQ5: output value changes only on valid mark
// RQ6: valid flag stays high while marks valid
// RQ7: value-new command updates parameters while running; ignored here during a remainder run
// RQ8: mode bits captured only at start command
// RQ9: difference mode outputs spacing minus command spacing
// RQ10: difference taken modulo the command spacing
// RQ11: positive limit range zero to spacing minus one
// RQ12: negative limit range minus spacing plus one to zero
// RQ13: no limit range minus half to plus half
// RQ14: positive limit needs spacing at least command
// RQ15: negative limit needs spacing below command
// RQ16: no limit: every in-window mark valid
// RQ17: reseed bit makes invalid mark new start
// RQ18: absolute mode outputs raw spacing, still blocked
// RQ19: mode bit0 absolute, bit1 reseed
// RQ20: mode bits three and two select limitation
// RQ21: command codes reset zero, start one, update five
// RQ22: blocked distance zero disables blocking
// RQ23: counter restarts at each new start point
// RQ24: reset command clears flags, counters, output production
module psm_pulse_spacing_meter
   import psm_pkg::*;
(
   // clock and reset
   input  wire logic                    i_clk,
   input  wire logic                    i_reset,
   // pulse generator input
   input  wire logic                    i_inc_a,
   input  wire logic                    i_inc_b,
   input  wire logic                    i_mark,
   // cyclic controller
   input  wire logic                    i_cycle_tick,
   input  wire logic                    i_cmd_valid,
   input  wire psm_cmd_s                i_cmd,
   // results
   output logic signed [VAL_W-1:0]      o_value,
   output logic                         o_new_value_strobe,
   output logic                         o_pulse_valid_flag,
   output logic                         o_running
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,   // basic state, nothing measured
      ST_ARMED = 4'b0010,   // waiting for the first start point
      ST_RUN   = 4'b0100,   // counting towards the next mark
      ST_CALC  = 4'b1000    // remainder being formed
   } psm_state_e;

   psm_state_e              state_reg;
   psm_state_e              state_next;
   logic [3:0]              mode_reg;
   logic [PAR_W-1:0]        spacing_reg;
   logic [PAR_W-1:0]        window_reg;
   logic [PAR_W-1:0]        blocked_reg;
   logic [CNT_W-1:0]        count_reg;
   logic [CNT_W-1:0]        count_next;
   logic [CNT_W-1:0]        cap_reg;
   logic                    mark_d_reg;
   logic                    blk_arm_reg;
   logic                    pend_reg;
   logic signed [VAL_W-1:0] pend_val_reg;

   logic                    step;
   logic                    mark_rise;
   logic                    cmd_start;
   logic                    cmd_reset;
   logic                    cmd_update;
   logic                    in_blocked;
   logic                    take_mark;
   logic                    mod_done;
   logic [CNT_W-1:0]        mod_rem;
   logic                    decide;
   logic                    valid;
   logic                    restart;
   logic signed [VAL_W-1:0] result;
   logic                    abs_mode;
   logic                    reseed;
   logic [1:0]              lim;
   logic signed [CNT_W:0]   rem_s;
   logic signed [CNT_W:0]   sp_s;
   logic signed [CNT_W:0]   u_none;
   logic signed [CNT_W:0]   u_neg;
   logic [CNT_W:0]          u_mag;
   logic                    in_win;

   // ------------------------------------------------------------
   // encoder edges and remainder unit
   // ------------------------------------------------------------
   psm_quad_edge u_edge (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_inc_a (i_inc_a),
      .i_inc_b (i_inc_b),
      .o_step  (step)
   );

   psm_modulo u_mod (
      .i_clk      (i_clk),
      .i_reset    (i_reset),
      .i_start    (take_mark),
      .i_dividend (count_reg),
      .i_divisor  (spacing_reg),
      .o_done     (mod_done),
      .o_rem      (mod_rem)
   );

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   // only the three documented codes act; others are ignored
   assign cmd_start  = i_cmd_valid && (i_cmd.code == CMD_START);     // RQ21
   assign cmd_reset  = i_cmd_valid && (i_cmd.code == CMD_RESET);     // RQ21
   assign cmd_update = i_cmd_valid && (i_cmd.code == CMD_VALUE_NEW)
                       && (state_reg != ST_IDLE);                    // RQ21

   // mode fields come from the copy taken at start
   assign abs_mode = mode_reg[MODE_ABS_BIT];                         // RQ19
   assign reseed   = mode_reg[MODE_RESEED_BIT];                      // RQ19
   assign lim      = mode_reg[MODE_LIM_LSB +: 2];                    // RQ20

   // ------------------------------------------------------------
   // mark detection
   // ------------------------------------------------------------
   // previous mark level for rising edge detection
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         mark_d_reg <= 1'b0;
      end else begin
         mark_d_reg <= i_mark;
      end
   end

   assign mark_rise = i_mark & ~mark_d_reg;

   // blocking only follows a valid mark, and a zero distance disables it
   assign in_blocked = blk_arm_reg && (blocked_reg != PAR_RST)
                       && (count_reg < {2'b00, blocked_reg});       // RQ3 RQ22

   // a mark is evaluated only while counting; marks during a
   // remainder run are dropped, which bounds the mark rate
   assign take_mark = (state_reg == ST_RUN) && mark_rise && !in_blocked
                      && !cmd_start && !cmd_reset;                   // RQ1

   assign decide = (state_reg == ST_CALC) && mod_done;

   // ------------------------------------------------------------
   // evaluation of one captured spacing
   // ------------------------------------------------------------
   assign rem_s  = $signed({1'b0, mod_rem});
   assign sp_s   = $signed({3'b000, spacing_reg});
   // signed difference folded into minus half .. plus half
   assign u_none = (mod_rem > {3'b000, spacing_reg[PAR_W-1:1]})
                   ? rem_s - sp_s : rem_s;                           // RQ10 RQ13
   assign u_neg  = (mod_rem == CNT_RST) ? rem_s : rem_s - sp_s;     // RQ12
   assign u_mag  = u_none[CNT_W] ? 33'(-u_none) : 33'(u_none);
   assign in_win = (window_reg == PAR_RST)
                   || (u_mag <= {3'b000, window_reg});               // RQ2

   // validity and output value for the captured spacing
   always_comb begin
      valid  = 1'b0;
      result = VAL_RST;
      if (abs_mode) begin
         valid  = 1'b1;                                              // RQ18
         result = $signed(cap_reg);                                  // RQ18
      end else if (spacing_reg == PAR_RST) begin
         // no command spacing: the value reproduces the spacing
         valid  = 1'b1;
         result = $signed(cap_reg);
      end else begin
         case (lim)
            LIM_POS: begin
               valid  = in_win && (cap_reg >= {2'b00, spacing_reg});  // RQ14
               result = $signed(mod_rem);                            // RQ11
            end
            LIM_NEG: begin
               valid  = in_win && (cap_reg < {2'b00, spacing_reg});   // RQ15
               result = u_neg[VAL_W-1:0];                            // RQ12
            end
            LIM_NONE: begin
               valid  = in_win;                                      // RQ16
               result = u_none[VAL_W-1:0];                           // RQ9 RQ13
            end
            default: begin
               // undefined limitation code acts as no limitation
               valid  = in_win;
               result = u_none[VAL_W-1:0];
            end
         endcase
      end
   end

   // an invalid mark becomes the start point only with the reseed bit
   assign restart = decide && (valid || reseed);                     // RQ17 RQ23

   // ------------------------------------------------------------
   // state machine
   // ------------------------------------------------------------
   // next state; reset command wins over a start in the same cycle
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (cmd_start) begin
               state_next = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (mark_rise) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (take_mark) begin
               state_next = ST_CALC;
            end
         end
         ST_CALC: begin
            if (mod_done) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      if (cmd_start && (state_reg != ST_IDLE)) begin
         state_next = ST_ARMED;
      end
      if (cmd_reset) begin
         state_next = ST_IDLE;                                       // RQ24
      end
   end

   // state register
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------
   // parameters and mode
   // ------------------------------------------------------------
   // mode only at start; spacing, window and blocked also on update
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         mode_reg    <= MODE_RST;
         spacing_reg <= PAR_RST;
         window_reg  <= PAR_RST;
         blocked_reg <= PAR_RST;
      end else if (cmd_start) begin
         mode_reg    <= i_cmd.mode;                                  // RQ8
         spacing_reg <= i_cmd.spacing;
         window_reg  <= i_cmd.window;
         blocked_reg <= i_cmd.blocked;
      end else if (cmd_update && (state_reg != ST_CALC)) begin
         // ignored during a remainder run so the divisor stays put
         spacing_reg <= i_cmd.spacing;                               // RQ7
         window_reg  <= i_cmd.window;                                // RQ7
         blocked_reg <= i_cmd.blocked;                               // RQ7
      end
   end

   // ------------------------------------------------------------
   // increment counter
   // ------------------------------------------------------------
   // the counter keeps running during a remainder run; on a restart
   // the increments seen since the mark are carried over
   always_comb begin
      count_next = count_reg;
      if (state_reg == ST_IDLE || cmd_start) begin
         count_next = CNT_RST;                                       // RQ24
      end else if (state_reg == ST_ARMED && mark_rise) begin
         count_next = CNT_RST;                                       // RQ23
      end else if (restart) begin
         count_next = count_reg - cap_reg;                           // RQ23
      end
      if (step && state_reg != ST_IDLE && !cmd_start && !cmd_reset
          && count_next != CNT_MAX) begin
         count_next = count_next + 32'h0000_0001;                    // RQ1
      end
      if (cmd_reset) begin
         count_next = CNT_RST;                                       // RQ24
      end
   end

   // counter register
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         count_reg <= CNT_RST;
      end else begin
         count_reg <= count_next;
      end
   end

   // spacing captured at the mark
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cap_reg <= CNT_RST;
      end else if (take_mark) begin
         cap_reg <= count_reg;                                       // RQ1
      end
   end

   // blocking armed by a valid mark, disarmed by any other start point
   always_ff @(posedge i_clk) begin
      if (i_reset || cmd_reset || cmd_start) begin
         blk_arm_reg <= 1'b0;
      end else if (decide && valid) begin
         blk_arm_reg <= 1'b1;                                        // RQ3
      end else if (restart) begin
         blk_arm_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // result hand-off on the function cycle
   // ------------------------------------------------------------
   // pending result; a new value in the tick cycle is kept, not lost
   always_ff @(posedge i_clk) begin
      if (i_reset || cmd_reset || cmd_start) begin
         pend_reg     <= 1'b0;
         pend_val_reg <= VAL_RST;
      end else if (decide && valid) begin
         pend_reg     <= 1'b1;                                       // RQ5
         pend_val_reg <= result;                                     // RQ5
      end else if (i_cycle_tick) begin
         pend_reg     <= 1'b0;
      end
   end

   // output value written only from a valid pending result
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_value <= VAL_RST;
      end else if (i_cycle_tick && pend_reg && !cmd_reset) begin
         o_value <= pend_val_reg;                                    // RQ5
      end
   end

   // strobe spans exactly one function cycle, tick to tick
   always_ff @(posedge i_clk) begin
      if (i_reset || cmd_reset) begin
         o_new_value_strobe <= 1'b0;                                 // RQ24
      end else if (i_cycle_tick) begin
         o_new_value_strobe <= pend_reg;                             // RQ4
      end
   end

   // valid flag follows the verdict on each evaluated mark
   always_ff @(posedge i_clk) begin
      if (i_reset || cmd_reset || cmd_start) begin
         o_pulse_valid_flag <= 1'b0;                                 // RQ24
      end else if (decide) begin
         o_pulse_valid_flag <= valid;                                // RQ6
      end
   end

   // running indication for the controller
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_running <= 1'b0;
      end else begin
         o_running <= (state_next != ST_IDLE);
      end
   end

endmodule

// ### psm_quad_edge.sv
// increment edge detector for the two encoder increment lines
`timescale 1ns/10ps
module psm_quad_edge
   import psm_pkg::*;
(
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset,
   // increment lines
   input  wire logic i_inc_a,
   input  wire logic i_inc_b,
   // one pulse per increment edge
   output logic      o_step
);

   logic a_d_reg;
   logic b_d_reg;

   // previous line levels
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         a_d_reg <= 1'b0;
         b_d_reg <= 1'b0;
      end else begin
         a_d_reg <= i_inc_a;
         b_d_reg <= i_inc_b;
      end
   end

   // any edge on either line is one increment; direction is not used
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_step <= 1'b0;
      end else begin
         o_step <= (i_inc_a ^ a_d_reg) | (i_inc_b ^ b_d_reg);
      end
   end

endmodule

// ### tb.sv
// self-checking bench of the pulse spacing meter
`timescale 1ns/10ps
module tb;
   import psm_pkg::*;
   logic                    i_clk = 1'b0;
   logic                    i_reset = 1'b1;
   logic                    i_cycle_tick = 1'b0;
   logic                    i_cmd_valid = 1'b0;
   psm_cmd_s                i_cmd = '0;
   logic                    i_inc_a, i_inc_b, i_mark;
   logic signed [VAL_W-1:0] o_value;
   logic                    o_new_value_strobe, o_pulse_valid_flag, o_running;
   int                      error_cnt = 0, n_compared = 0, strobes = 0, tcnt = 0;
   int                      acc, s_par, w_par, b_par;
   int                      sc1[6] = '{37, 103, 96, 150, 50, 203};
   int                      sc2[3] = '{62, 10, 48};
   int                      sc3[4] = '{5, 300, 10, 40};
   logic [3:0]              mode;
   logic                    lastv, first, exp_flag, strobe_q = 1'b0;
   logic [31:0]             exp_val, seed = 32'h0000_9119;

   psm_pulse_spacing_meter uut (.i_clk, .i_reset, .i_inc_a, .i_inc_b, .i_mark, .i_cycle_tick,
      .i_cmd_valid, .i_cmd, .o_value, .o_new_value_strobe, .o_pulse_valid_flag, .o_running);
   psm_enc_model enc (.i_clk, .o_inc_a(i_inc_a), .o_inc_b(i_inc_b), .o_mark(i_mark));

   always #2 i_clk = ~i_clk;
   // tick every five clocks; count strobe pulses
   always @(posedge i_clk) begin
      strobes <= strobes + int'(o_new_value_strobe && !strobe_q);
      strobe_q <= o_new_value_strobe;
      #1;
      tcnt = (tcnt + 1) % 5;
      i_cycle_tick = (tcnt == 0);
   end
   // ----
   // helpers
   // ----
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // expected {valid, value} for a spacing n
   function automatic logic [32:0] expect_of(input int n);
      int r, d;
      logic v;
      if (mode[MODE_ABS_BIT] || s_par == 0) return {1'b1, 32'(n)};
      r = n % s_par;
      d = (r > s_par / 2) ? r - s_par : r;
      v = (w_par == 0) || (d <= w_par && -d <= w_par);
      case (mode[3:2])
         LIM_POS: return {v && n >= s_par, 32'(r)};
         LIM_NEG: return {v && n < s_par, 32'((r == 0) ? 0 : r - s_par)};
         default: return {v, 32'(d)};
      endcase
   endfunction
   task automatic chk_val(input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, exp);
      chk_val(32'(got), 32'(exp));
   endtask
   task automatic cmd(input logic [7:0] c, input logic [3:0] m, input int s, w, b);
      @(posedge i_clk);
      #1;
      i_cmd_valid = 1'b1;
      i_cmd = '{code: c, mode: m, spacing: PAR_W'(s), window: PAR_W'(w), blocked: PAR_W'(b)};
      s_par = s;
      w_par = w;
      b_par = b;
      @(posedge i_clk);
      #1;
      i_cmd_valid = 1'b0;
   endtask
   task automatic start(input logic [3:0] m, input int s, w, b);
      mode = m;
      first = 1'b1;
      lastv = 1'b0;
      acc = 0;
      cmd(CMD_START, m, s, w, b);
   endtask
   // n increments then a mark; blocked marks must leave no trace
   task automatic meas(input int n);
      logic [32:0] e;
      int s0;
      e = '0;
      s0 = strobes;
      enc.move(n);
      enc.mark();
      repeat (12) @(posedge i_clk);
      acc += n;
      if (first) begin
         first = 1'b0;
         acc = 0;
         return;
      end else if (!(lastv && b_par != 0 && acc < b_par)) begin
         e = expect_of(acc);
         exp_flag = e[32];
         if (e[32]) exp_val = e[31:0];
         if (e[32] || mode[MODE_RESEED_BIT]) acc = 0;
         lastv = e[32];
      end
      chk_val(o_value, exp_val);
      chk_bit(o_pulse_valid_flag, exp_flag);
      chk_val(32'(strobes - s0), 32'(e[32]));
   endtask
   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ----
   // sequence
   // ----
   initial begin
      exp_val = 32'h0000_0000;
      exp_flag = 1'b0;
      repeat (16) @(posedge i_clk);
      #1;
      i_reset = 1'b0;
      chk_bit(o_running, 1'b0);
      start(4'h0, 100, 10, 0);
      chk_bit(o_running, 1'b1);
      foreach (sc1[k]) meas(sc1[k]);
      // live update, junk mode bits, blocking, then none
      cmd(CMD_VALUE_NEW, 4'(xs()), 60, 4, 30);
      foreach (sc2[k]) meas(sc2[k]);
      cmd(CMD_VALUE_NEW, 4'(xs()), 60, 4, 0);
      meas(5);
      for (int k = 0; k < 6; k++) begin
         start({2'(k % 3), 1'(k / 3), 1'b0}, 80, 6, 0);
         meas(5);
         repeat (6) meas(70 + int'(xs() % 21));
      end
      start(4'h1, 80, 1, 20);
      foreach (sc3[k]) meas(sc3[k]);
      cmd(CMD_RESET, 4'h0, 0, 0, 0);
      chk_bit(o_running, 1'b0);
      chk_bit(o_pulse_valid_flag, 1'b0);
      acc = strobes;
      enc.move(50);
      enc.mark();
      chk_val(32'(strobes - acc), 32'h0000_0000);
      print_verdict();
   end
   // watchdog past the expected run length
   initial begin
      repeat (40000) @(posedge i_clk);
      error_cnt++;
      print_verdict();
   end
endmodule
